// ===== verilog/sael_encoder.sv
// Encoder end of the serial absolute position link.
// Assumes the controller drives the serial clock and keeps the pause.
`timescale 1ns/1ps
`default_nettype none
`include "sael_regs.svh"
module sael_encoder #(
  parameter int unsigned MONO_CYC = `SAEL_MONO_CYC,
  parameter int unsigned ZERO_CYC = `SAEL_ZERO_HOLD_CYC
) (
  // System
  input  wire logic              sys_clk_i,
  input  wire logic              rst_i,
  // Link
  sael_link_if.enc               link,
  // Sensor side
  input  wire sael_pkg::sael_pos_t raw_pos_i,
  input  wire logic              special_i,
  input  wire logic              dir_i,
  input  wire logic              zero_set_i,
  input  wire logic              gray_sel_i,
  // Status
  output logic                   busy_o
);
  import sael_pkg::*;

  // =====================================================================
  // Helpers
  function automatic sael_pos_t to_gray(input sael_pos_t b);
    to_gray = b ^ (b >> 1);
  endfunction

  logic       clk_s;        // Synchronised serial clock
  logic       clk_d_ff;     // Previous sampled clock
  logic       zs_s;         // Synchronised zero-set
  logic       zs_d_ff;      // Previous zero-set
  logic       dir_s;        // Synchronised direction input
  sael_word_t shreg_ff;     // Captured word
  logic [4:0] bit_ff;       // Rising edges seen in this word
  logic       act_ff;       // Transfer in progress
  logic       data_ff;      // Serial data output
  logic [31:0] mono_ff;     // Monoflop counter
  logic       zarm_ff;      // Zero-set armed after falling edge
  logic [31:0] zcnt_ff;     // Zero-set hold counter
  sael_pos_t  offs_ff;      // Zero offset

  // Serial clock, zero-set and direction come from outside this clock;
  // each passes three flops and counts once stages two and three agree.
  // All rest high, so no false edge appears when reset lets go.
  sael_sync u_clk (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .rst_val_i (1'b1),
    .async_i   (link.sclk),
    .sync_o    (clk_s)
  );
  sael_sync u_zs (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .rst_val_i (1'b1),
    .async_i   (zero_set_i),
    .sync_o    (zs_s)
  );
  sael_sync u_dir (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .rst_val_i (1'b1),
    .async_i   (dir_i),
    .sync_o    (dir_s)
  );

  // =====================================================================
  // Edge decode and position word
  wire        fall    = clk_d_ff & ~clk_s;
  wire        rise    = ~clk_d_ff & clk_s;
  wire        mono_run = (mono_ff != 32'h0);
  wire        zs_fall = zs_d_ff & ~zs_s;
  // Direction: low counts up clockwise, high counts down
  wire sael_pos_t dir_pos = dir_s ? sael_pos_t'(-raw_pos_i) : raw_pos_i;
  wire sael_pos_t pos_z   = dir_pos - offs_ff;
  // Gray or binary output
  wire sael_pos_t pos_c   = gray_sel_i ? to_gray(pos_z) : pos_z;
  wire sael_word_t fresh  = {pos_c, 11'h000, special_i};
  // Word end after 25 rising edges
  wire        word_end = (bit_ff == 5'(`SAEL_WORD_W));
  // A falling edge with no transfer running, or a late one, starts fresh
  wire        fresh_cap = fall & (~act_ff | ~mono_run);

  // =====================================================================
  // Clock and zero-set edge history
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      clk_d_ff <= 1'b1;
      zs_d_ff  <= 1'b1;
    end else begin
      clk_d_ff <= clk_s;
      zs_d_ff  <= zs_s;
    end
  end

  // =====================================================================
  // Shift engine
  // One pulse is a fall and then a rise of the serial clock:
  //   fall 1      latches position and special bit, data unchanged
  //   rise 1..25  present bit 24 down to bit 0
  //   fall 26     data goes low after the last bit
  //   rise 26     data stays low; return to idle, or the separator
  //               ahead of a repeated copy
  //   fall 27..   further pulses inside the timeout resend the word
  // A clock resting high until the timeout runs out ends the transfer;
  // the next fall then latches a fresh word.
  // A fresh capture beats every other action in the same cycle.
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      shreg_ff <= '0;
      bit_ff   <= 5'h00;
      act_ff   <= 1'b0;
      data_ff  <= 1'b1;
    end else if (fresh_cap) begin
      // Capture: word, bit count and busy flag
      shreg_ff <= fresh;
      bit_ff   <= 5'h00;
      act_ff   <= 1'b1;
    end else if (act_ff && rise) begin
      if (word_end) begin
        // Separator low; a further pulse resends the stored word
        data_ff <= 1'b0;
        bit_ff  <= 5'h00;
      end else begin
        // MSB first, then lower bits
        data_ff <= shreg_ff[`SAEL_WORD_W-1-bit_ff];
        bit_ff  <= bit_ff + 5'h01;
      end
    end else if (act_ff && fall && word_end) begin
      data_ff <= 1'b0;
    end else if (act_ff && !mono_run && clk_s) begin
      // Timeout with clock high: back to idle
      data_ff <= 1'b1;
      act_ff  <= 1'b0;
    end
  end

  // =====================================================================
  // Monoflop, retriggered by each falling edge
  // Runs throughout a burst, since the clock period stays below it;
  // reaching zero with the clock high is what ends a transfer.
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      mono_ff <= 32'h0;
    end else if (fall) begin
      mono_ff <= MONO_CYC;
    end else if (mono_run) begin
      mono_ff <= mono_ff - 32'h1;
    end
  end

  // =====================================================================
  // Zero-set: falling edge, then held low for the hold time
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      zarm_ff <= 1'b0;
      zcnt_ff <= 32'h0;
      offs_ff <= '0;
    end else if (zs_fall) begin
      // Fall seen: arm and restart the hold count
      zarm_ff <= 1'b1;
      zcnt_ff <= 32'h0;
    end else if (zarm_ff && zs_s) begin
      // Released too early: disarm, offset kept
      zarm_ff <= 1'b0;
    end else if (zarm_ff) begin
      // Held long enough: the present angle reads zero from now on
      if (zcnt_ff >= ZERO_CYC - 1) begin
        offs_ff <= dir_pos;
        zarm_ff <= 1'b0;
      end else begin
        zcnt_ff <= zcnt_ff + 32'h1;
      end
    end
  end

  // =====================================================================
  // Outputs
  assign link.sdata = data_ff;
  assign busy_o     = act_ff;
endmodule
`default_nettype wire

// ===== verilog/sael_regs.svh
// Constants of the serial absolute encoder link: word layout and timing counts.
// Assumes a 100 MHz system clock on both ends.
`ifndef SAEL_REGS_SVH
`define SAEL_REGS_SVH
// =====================================================================
// Word layout
`define SAEL_POS_W        13
`define SAEL_WORD_W       25
`define SAEL_SPECIAL_POS  0
`define SAEL_POS_LSB      1
// =====================================================================
// Timing
`define SAEL_SYS_PERIOD_NS 10
`define SAEL_MONO_US       20
`define SAEL_MONO_CYC      ((`SAEL_MONO_US * 1000) / `SAEL_SYS_PERIOD_NS)
`define SAEL_ZERO_HOLD_MS  1100
`define SAEL_ZERO_HOLD_CYC (`SAEL_ZERO_HOLD_MS * 100000)
`define SAEL_HALF_PER_CYC  25
`define SAEL_PAUSE_CYC     ((`SAEL_MONO_US * 1000) / `SAEL_SYS_PERIOD_NS + 100)
`endif

// ===== verilog/sael_pkg.sv
// Types shared by both ends of the encoder link.
// Assumes sael_regs.svh for numeric constants.
`include "sael_regs.svh"
package sael_pkg;
  typedef logic [`SAEL_WORD_W-1:0] sael_word_t;
  typedef logic [`SAEL_POS_W-1:0]  sael_pos_t;
endpackage

// ===== verilog/sael_link_if.sv
// Wires between controller and encoder: serial clock and serial data.
// Assumes both ends share one testbench; levels are plain one-way.
`timescale 1ns/1ps
`default_nettype none
interface sael_link_if;
  logic sclk;   // Serial clock, controller to encoder
  logic sdata;  // Serial data, encoder to controller
  modport enc (input sclk, output sdata);
  modport ctl (output sclk, input sdata);
endinterface
`default_nettype wire

// ===== verilog/sael_sync.sv
// Three-stage input synchroniser with agreement filter.
// Assumes an asynchronous input and the local system clock.
`timescale 1ns/1ps
`default_nettype none
module sael_sync (
  // System
  input  wire logic sys_clk_i,
  input  wire logic rst_i,
  input  wire logic rst_val_i,
  // Signal
  input  wire logic async_i,
  output logic      sync_o
);
  logic s1_ff;  // Metastability stage
  logic s2_ff;  // Second stage
  logic s3_ff;  // Third stage
  logic hold_ff; // Accepted level
  // =====================================================================
  // Shift chain; accept once stages two and three agree
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      s1_ff   <= 1'b1;
      s2_ff   <= 1'b1;
      s3_ff   <= 1'b1;
      hold_ff <= 1'b1;
    end else begin
      s1_ff <= async_i;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      if (s2_ff == s3_ff) begin
        hold_ff <= s3_ff;
      end
    end
  end
  assign sync_o = hold_ff;
  wire unused_ok = rst_val_i;
endmodule
`default_nettype wire

// ===== verilog/sael_ctrl.sv
// Controller end: issues clock bursts, samples data, returns the word.
// Assumes the encoder answers as an SSI position source.
`timescale 1ns/1ps
`default_nettype none
`include "sael_regs.svh"
module sael_ctrl #(
  parameter int unsigned HALF_CYC  = `SAEL_HALF_PER_CYC,
  parameter int unsigned PAUSE_CYC = `SAEL_PAUSE_CYC
) (
  // System
  input  wire logic                sys_clk_i,
  input  wire logic                rst_i,
  // Link
  sael_link_if.ctl                 link,
  // User request
  input  wire logic                start_i,
  input  wire logic                repeat_i,
  output logic                     ready_o,
  // User answer
  output sael_pkg::sael_word_t     word_o,
  output logic                     valid_o,
  output logic                     mismatch_o
);
  import sael_pkg::*;
  typedef enum {ST_IDLE, ST_LOW, ST_HIGH, ST_PAUSE} sael_cst_t;

  sael_cst_t  st_ff;
  logic [31:0] cnt_ff;     // Phase/pause counter
  logic [5:0] bits_ff;     // Falling edges sent after the first
  logic       rep_ff;      // Send a repeat copy
  logic       clk_ff;      // Serial clock out
  sael_word_t sh_ff;       // Receive shift
  sael_word_t word_ff;     // Last word
  logic       valid_ff;
  logic       mis_ff;
  logic       fin_ff;      // Last fall sent; next rise ends the burst
  logic       dat_s;       // Synchronised data

  sael_sync u_dat (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .rst_val_i(1'b1),
                   .async_i(link.sdata), .sync_o(dat_s));

  wire        ph_done  = (cnt_ff >= HALF_CYC - 1);
  // Index of the last sampling fall; a repeat adds a separator and a copy
  wire [5:0]  last_bit = rep_ff ? 6'(2 * `SAEL_WORD_W) : 6'(`SAEL_WORD_W - 1);
  wire sael_word_t sh_in = {sh_ff[`SAEL_WORD_W-2:0], dat_s};

  // =====================================================================
  // Burst sequencer; clock period well below the monoflop
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_ff    <= ST_IDLE;
      cnt_ff   <= 32'h0;
      bits_ff  <= 6'h00;
      rep_ff   <= 1'b0;
      fin_ff   <= 1'b0;
      clk_ff   <= 1'b1;
      sh_ff    <= '0;
      word_ff  <= '0;
      valid_ff <= 1'b0;
      mis_ff   <= 1'b0;
    end else begin
      valid_ff <= 1'b0;
      unique case (st_ff)
        ST_IDLE: begin
          clk_ff <= 1'b1;
          if (start_i) begin
            // First fall: the encoder latches its word
            st_ff   <= ST_LOW;
            clk_ff  <= 1'b0;
            cnt_ff  <= 32'h0;
            bits_ff <= 6'h00;
            fin_ff  <= 1'b0;
            rep_ff  <= repeat_i;
          end
        end
        ST_LOW: begin
          cnt_ff <= cnt_ff + 32'h1;
          if (ph_done) begin
            // Rise; after the last fall it is the return to idle
            clk_ff <= 1'b1;
            cnt_ff <= 32'h0;
            st_ff  <= fin_ff ? ST_PAUSE : ST_HIGH;
          end
        end
        ST_HIGH: begin
          cnt_ff <= cnt_ff + 32'h1;
          if (ph_done) begin
            // Sample on falling edge after the rising edge
            if (bits_ff != 6'(`SAEL_WORD_W)) begin
              sh_ff <= sh_in;
            end
            bits_ff <= bits_ff + 6'h01;
            cnt_ff  <= 32'h0;
            clk_ff  <= 1'b0;
            st_ff   <= ST_LOW;
            if (bits_ff == 6'(`SAEL_WORD_W - 1)) begin
              word_ff <= sh_in;
            end
            if (bits_ff == last_bit) begin
              fin_ff   <= 1'b1;
              valid_ff <= 1'b1;
              if (rep_ff) begin
                mis_ff <= (word_ff != sh_in);
              end else begin
                mis_ff <= 1'b0;
              end
            end
          end
        end
        ST_PAUSE: begin
          // Wait for data high, or pause expiry
          cnt_ff <= cnt_ff + 32'h1;
          if ((dat_s && cnt_ff > 32'h4) || cnt_ff >= PAUSE_CYC) begin
            st_ff <= ST_IDLE;
          end
        end
      endcase
    end
  end

  assign link.sclk  = clk_ff;
  assign ready_o    = (st_ff == ST_IDLE);
  assign word_o     = word_ff;
  assign valid_o    = valid_ff;
  assign mismatch_o = mis_ff;
endmodule
`default_nettype wire

// ===== sim/sael_link_assertions.sv
// Checker of the two link wires between controller and encoder.
// Assumes both wires are sampled by the one system clock of the bench.
`timescale 1ns/1ps
`default_nettype none
module sael_link_assertions #(
  parameter int MONO_CYC = 400,
  parameter int HALF_CYC = 25
) (
  // System
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // Link
  input wire logic sclk,
  input wire logic sdata
);
  // ==================================================================
  // Helper counters
  int hi_cnt;    // Cycles with clock high
  int lo_cnt;    // Cycles with clock low
  int fall_cnt;  // Clock falls in the current burst
  int edge_cnt;  // Cycles since the last clock change
  assign edge_cnt = sclk ? hi_cnt : lo_cnt;

  // Count levels and falls; a long high ends the burst
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      hi_cnt   <= 0;
      lo_cnt   <= 0;
      fall_cnt <= 0;
    end else begin
      hi_cnt   <= sclk ? ((hi_cnt < 99999) ? hi_cnt + 1 : hi_cnt) : 0;
      lo_cnt   <= sclk ? 0 : lo_cnt + 1;
      fall_cnt <= (!sclk && lo_cnt == 0) ? fall_cnt + 1 : (hi_cnt == 100) ? 0 : fall_cnt;
    end
  end

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);

  // ==================================================================
  // Wire checks
  AST_IDLE_HIGH: assert property (hi_cnt == MONO_CYC + 40 |-> sdata)
    else $error("data not high at idle");
  AST_START_ON_HIGH: assert property ($fell(sclk) && hi_cnt > 100 |-> sdata)
    else $error("burst began with data low");
  AST_DATA_AFTER_CLK: assert property ($fell(sdata) |-> edge_cnt <= 10)
    else $error("data fell without a clock edge");
  AST_STABLE_LOW: assert property (!sclk && edge_cnt > 10 |-> $stable(sdata))
    else $error("data moved while clock low");
  AST_MONO_EARLY: assert property ($rose(sdata) && edge_cnt > 10 |-> hi_cnt >= MONO_CYC - 40)
    else $error("data rose before timeout");
  AST_LOW_AFTER_LSB: assert property (hi_cnt == 60 && fall_cnt != 0 |-> !sdata)
    else $error("data not low after last bit");
  AST_BURST_LEN: assert property (hi_cnt == 60 && fall_cnt != 0 |-> fall_cnt inside {26, 52})
    else $error("burst length wrong");
  AST_HALF_PERIOD: assert property ($rose(sclk) |-> lo_cnt inside {[HALF_CYC-1:HALF_CYC+1]})
    else $error("clock low phase wrong");
endmodule
`default_nettype wire

// ===== sim/testbench.sv
// Self-checking bench: controller and encoder joined by the link.
// Assumes the design files compile first; counts are shortened for speed.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin err_count++; $display("[FAIL] t=%0t got=%h exp=%h", $time, (a), (b)); end end
module testbench;
  import sael_pkg::*;
  localparam int MONO = 400;  // Shortened monoflop
  localparam int HALF = 25;   // Half serial period
  // ==================================================================
  // Signals
  logic       sys_clk_i  = 1'b0;
  logic       rst_i      = 1'b1;
  sael_pos_t  raw_pos_i  = '0;
  logic       special_i  = 1'b0;
  logic       dir_i      = 1'b0;
  logic       zero_set_i = 1'b1;
  logic       gray_sel_i = 1'b0;
  logic       start_i    = 1'b0;
  logic       repeat_i   = 1'b0;
  logic       ready_o;
  logic       valid_o;
  logic       mismatch_o;
  logic       busy_o;
  sael_word_t word_o;
  sael_pos_t  zoff       = '0;  // Model zero offset
  int         err_count  = 0;
  int         comparisons = 0;
  int         r;

  sael_link_if link();
  sael_encoder #(.MONO_CYC(MONO), .ZERO_CYC(50)) i_sael_encoder (
    .sys_clk_i(sys_clk_i), .rst_i(rst_i), .link(link), .raw_pos_i(raw_pos_i),
    .special_i(special_i), .dir_i(dir_i), .zero_set_i(zero_set_i),
    .gray_sel_i(gray_sel_i), .busy_o(busy_o));
  sael_ctrl #(.HALF_CYC(HALF), .PAUSE_CYC(MONO + 100)) i_sael_ctrl (
    .sys_clk_i(sys_clk_i), .rst_i(rst_i), .link(link), .start_i(start_i),
    .repeat_i(repeat_i), .ready_o(ready_o), .word_o(word_o), .valid_o(valid_o),
    .mismatch_o(mismatch_o));
  sael_link_assertions #(.MONO_CYC(MONO), .HALF_CYC(HALF)) i_sael_link_assertions (
    .sys_clk_i(sys_clk_i), .rst_i(rst_i), .sclk(link.sclk), .sdata(link.sdata));

  // ==================================================================
  // Reference word: offset, direction, code, padding, special bit
  function automatic sael_word_t model(sael_pos_t raw, logic sp, logic d, logic g);
    sael_pos_t p;
    p = raw - zoff;
    if (d) p = -p;
    if (g) p = p ^ (p >> 1);
    return {p, 11'h000, sp};
  endfunction

  // One transfer; the angle moves after capture to catch late sampling
  task automatic xfer(input sael_pos_t raw, input logic sp, d, g, rep);
    sael_word_t exp;
    int n;
    raw_pos_i = raw;
    special_i = sp;
    dir_i = d;
    gray_sel_i = g;
    repeat_i = rep;
    exp = model(raw, sp, d, g);
    @(negedge sys_clk_i);
    start_i = 1'b1;
    n = 0;
    do begin
      @(negedge sys_clk_i);
      n++;
    end while (ready_o !== 1'b0 && n < 10);
    start_i = 1'b0;
    repeat (3 * HALF) @(negedge sys_clk_i);
    `CHK(busy_o, 1'b1)
    raw_pos_i = raw ^ 13'h0155;
    n = 0;
    while (valid_o !== 1'b1 && n < 4000) begin
      @(negedge sys_clk_i);
      n++;
    end
    `CHK(word_o, exp)
    if (rep) `CHK(mismatch_o, 1'b0)
    n = 0;
    while (ready_o !== 1'b1 && n < 1000) begin
      @(negedge sys_clk_i);
      n++;
    end
    `CHK(ready_o, 1'b1)
  endtask

  // Verdict and end of run
  task automatic end_of_test();
    $display("comparisons=%0d err_count=%0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Free-running system clock
  initial begin
    forever #5 sys_clk_i = ~sys_clk_i;
  end

  // Hang guard
  initial begin
    repeat (90000) @(posedge sys_clk_i);
    err_count++;
    end_of_test();
  end

  // Main sequence
  initial begin
    r = $urandom(49848);
    repeat (20) @(negedge sys_clk_i);
    rst_i = 1'b0;
    repeat (100) @(negedge sys_clk_i);
    `CHK({link.sclk, link.sdata}, 2'b11)
    // Every mix of repeat, code and direction, ends of range first
    for (int i = 0; i < 16; i++) begin
      r = (i == 0) ? 0 : (i == 1) ? 32'h1FFF : $urandom;
      xfer(r[12:0], r[20], i[2], i[1], i[0]);
    end
    // Zero the shaft at some angle, then read it and a nearby angle
    raw_pos_i = 13'h0A5A;
    dir_i = 1'b0;
    zero_set_i = 1'b0;
    repeat (60) @(negedge sys_clk_i);
    zero_set_i = 1'b1;
    zoff = 13'h0A5A;
    xfer(13'h0A5A, 1'b1, 1'b0, 1'b0, 1'b0);
    xfer(13'h0A5D, 1'b0, 1'b0, 1'b1, 1'b1);
    end_of_test();
  end
endmodule
`default_nettype wire
